// ==== hdl/wdog_pkg.sv ====
/*
 * constants, state encodings and the state record of the watchdog,
 * clock monitor and system option logic.
 * assumes one system clock of 250 MHz; the e clock arrives on a pin.
 */
package wdog_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [15:0] ADDR_OPTIONS = 16'h1039;
	localparam logic [15:0] ADDR_SERVICE = 16'h103A;
	localparam logic [15:0] ADDR_PRIORITY = 16'h103C;
	localparam logic [15:0] ADDR_TEST = 16'h103F;

	// ****************************************************************
	// option register fields
	// ****************************************************************
	localparam int OPT_PWR_BIT = 7;
	localparam int OPT_PUMP_BIT = 6;
	localparam int OPT_EDGE_BIT = 5;
	localparam int OPT_WAIT_BIT = 4;
	localparam int OPT_MON_BIT = 3;
	localparam int OPT_RATE_LSB = 0;
	localparam logic [7:0] OPT_FREE_MASK = 8'hC8;
	localparam logic [7:0] OPT_ONCE_MASK = 8'h33;
	localparam logic [7:0] OPT_RESET = 8'h10;
	localparam logic [3:0] PSEL_RESET = 4'h5;
	localparam logic [7:0] SERVICE_ARM = 8'h55;
	localparam logic [7:0] SERVICE_FIRE = 8'hAA;
	localparam logic [7:0] READ_JUNK = 8'h00;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_PERIOD_PS = 4000;
	localparam int CM_TIMEOUT_NS = 50000;
	localparam int CM_TIMEOUT_CYCLES = (CM_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
	localparam int WD_SHIFT_MIN = 15;
	localparam logic [6:0] LOCK_TICKS = 7'h40;
	localparam logic [11:0] STOP_DELAY_TICKS = 12'hFE0;
	localparam logic [2:0] DRIVE_TICKS = 3'h4;
	localparam logic [2:0] SAMPLE_TICKS = 3'h2;
	localparam logic [2:0] STRAP_SETTLE = 3'h6;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {
		RS_IDLE,
		RS_DRIVE,
		RS_SAMPLE
	} rst_phase_t;

	typedef enum logic [1:0] {
		CAUSE_EXT,
		CAUSE_WDOG,
		CAUSE_CMON
	} cause_t;

	typedef struct packed {
		logic [2:0] e_s;
		logic [2:0] pin_s;
		logic [2:0] irq_s;
		logic [2:0] ma_s;
		logic [2:0] mb_s;
		logic e_f;
		logic pin_f;
		logic irq_f;
		logic ma_f;
		logic mb_f;
		logic [7:0] opt;
		logic locked;
		logic [6:0] lock_cnt;
		logic [2:0] settle;
		logic strap_done;
		logic boot;
		logic spec;
		logic mode_a;
		logic [3:0] psel;
		logic wd_block;
		logic [20:0] wd_cnt;
		logic armed;
		logic [15:0] cm_cnt;
		rst_phase_t phase;
		logic [2:0] ph_cnt;
		cause_t cause;
		logic irq_pend;
		logic stop_wait;
		logic [11:0] stop_cnt;
		logic [7:0] rdata;
	} state_t;

endpackage : wdog_pkg

// ==== hdl/cop_watchdog_clock_monitor.sv ====
/*
 * watchdog timer, clock monitor, reset pin sequencer, system options
 * and priority configuration with a plain register port.
 * assumes the e clock, reset pin, irq pin and mode pins are asynchronous
 * pins; the watchdog disable cell is a level on the system clock.
 */
// Chosen here: the plain strobed port.
// Behaviour
// RULE1 - reset loads priority select with 0101, external irq highest.
// RULE2 - reset leaves the irq pin level sensitive.
// RULE3 - boot, special and mode-a flags capture mode pins at reset end.
// RULE4 - reset sets the stop exit delay bit.
// RULE5 - reset clears the clock monitor enable bit.
// RULE6 - watchdog timeout resets only if disable clear and not blocked.
// RULE7 - rate select picks 2^15, 2^17, 2^19 or 2^21 e clocks.
// RULE8 - reset clears both rate select bits.
// RULE9 - software writes 55 then AA to the service register.
// RULE10 - service sequences must complete before each timeout.
// RULE11 - other bus cycles between the two writes keep the sequence.
// RULE12 - reads of the service register return junk, no effect.
// RULE13 - watchdog reset reports its own cause for a separate vector.
// RULE14 - enabled monitor fails when no e clock edge for 50 us.
// RULE15 - monitor failure resets and drives reset pin low; own cause.
// RULE16 - stop entry with monitor enabled gives a monitor reset.
// RULE17 - option bits 7, 6, 3 always writable; others write once.
// RULE18 - without a write in 64 e clocks, once-bits lock.
// RULE19 - special mode lets every option bit be written repeatedly.
// RULE20 - edge bit 0 means low level irq, 1 means falling edges.
// RULE21 - delay bit set waits 4064 e clocks after stop wake-up.
// RULE22 - charge pump select 0 uses e clock, 1 the rc oscillator.
// RULE23 - option bit 2 is not implemented and reads zero.
// RULE24 - only AA after a 55 restarts the watchdog counter.
`timescale 1ns/1ps

module cop_watchdog_clock_monitor #(
	parameter logic [15:0] CM_TIMEOUT = 16'(wdog_pkg::CM_TIMEOUT_CYCLES),
	parameter int WD_SHIFT = wdog_pkg::WD_SHIFT_MIN
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// register port
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// pins
	input wire logic e_clk_i,
	input wire logic reset_pin_i,
	output logic reset_pin_o,
	output logic reset_pin_oe_n_o,
	input wire logic irq_pin_n_i,
	input wire logic mode_select_a_input_i,
	input wire logic mode_select_b_input_i,
	input wire logic watchdog_disable_i,
	// stop mode
	input wire logic stop_i,
	input wire logic wake_i,
	output logic run_enable_o,
	// system
	output logic sys_reset_o,
	output logic [1:0] reset_cause_o,
	output logic irq_request_o,
	input wire logic irq_ack_i,
	output logic [3:0] priority_select_o,
	output logic boot_rom_enable_o,
	output logic special_mode_flag_o,
	output logic mode_a_flag_o,
	output logic converter_power_up_o,
	output logic rc_osc_enable_o,
	output logic converter_e_clk_o
);

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic filt(input logic [2:0] s, input logic f);
		filt = (s[1] == s[2]) ? s[2] : f;
	endfunction : filt

	function automatic logic [20:0] wd_limit(input logic [1:0] rate);
		logic [5:0] sh;
		sh = 6'(WD_SHIFT) + {3'h0, rate, 1'b0};
		wd_limit = (21'h000001 << sh) - 21'h000001;
	endfunction : wd_limit

	localparam wdog_pkg::state_t ST_INIT = '{
		pin_s: 3'h7, irq_s: 3'h7, pin_f: 1'b1, irq_f: 1'b1,
		opt: wdog_pkg::OPT_RESET, psel: wdog_pkg::PSEL_RESET,
		phase: wdog_pkg::RS_IDLE, cause: wdog_pkg::CAUSE_EXT,
		default: '0};

	wdog_pkg::state_t st_reg;
	wdog_pkg::state_t st_next;
	logic e_tick;
	logic sys_rst;
	logic wd_en;
	logic wd_fire;
	logic cm_fail;
	logic svc_wr;
	logic opt_wr;

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		st_next = st_reg;
		st_next.e_s = {st_reg.e_s[1:0], e_clk_i};
		st_next.pin_s = {st_reg.pin_s[1:0], reset_pin_i};
		st_next.irq_s = {st_reg.irq_s[1:0], irq_pin_n_i};
		st_next.ma_s = {st_reg.ma_s[1:0], mode_select_a_input_i};
		st_next.mb_s = {st_reg.mb_s[1:0], mode_select_b_input_i};
		st_next.e_f = filt(st_reg.e_s, st_reg.e_f);
		st_next.pin_f = filt(st_reg.pin_s, st_reg.pin_f);
		st_next.irq_f = filt(st_reg.irq_s, st_reg.irq_f);
		st_next.ma_f = filt(st_reg.ma_s, st_reg.ma_f);
		st_next.mb_f = filt(st_reg.mb_s, st_reg.mb_f);
		e_tick = ~st_reg.e_f & st_next.e_f;
		sys_rst = (st_reg.phase != wdog_pkg::RS_IDLE) | ~st_reg.pin_f;
		svc_wr = wr_i & (addr_i == wdog_pkg::ADDR_SERVICE);
		opt_wr = wr_i & (addr_i == wdog_pkg::ADDR_OPTIONS);
		wd_en = ~watchdog_disable_i & ~(st_reg.spec & st_reg.wd_block); // [RULE6]
		wd_fire = wd_en & e_tick &
			(st_reg.wd_cnt == wd_limit(st_reg.opt[1:0])); // [RULE7]
		cm_fail = st_reg.opt[wdog_pkg::OPT_MON_BIT] &
			(stop_i | (st_reg.cm_cnt >= CM_TIMEOUT - 16'h0001)); // [RULE14] [RULE16]

		if (sys_rst) begin
			// system reset returns the option state to defaults
			st_next.opt = wdog_pkg::OPT_RESET; // [RULE2] [RULE4] [RULE5] [RULE8]
			st_next.psel = wdog_pkg::PSEL_RESET; // [RULE1]
			st_next.locked = 1'b0;
			st_next.lock_cnt = '0;
			st_next.armed = 1'b0;
			st_next.wd_cnt = '0;
			st_next.cm_cnt = '0;
			st_next.stop_wait = 1'b0;
			st_next.stop_cnt = '0;
			st_next.irq_pend = 1'b0;
			st_next.wd_block = 1'b0;
			st_next.strap_done = 1'b0;
			st_next.settle = '0;
		end else begin
			// strap capture once the mode pins have settled
			if (!st_reg.strap_done) begin
				if (st_reg.settle == wdog_pkg::STRAP_SETTLE) begin
					st_next.strap_done = 1'b1;
					st_next.boot = ~st_reg.mb_f & ~st_reg.ma_f; // [RULE3]
					st_next.spec = ~st_reg.mb_f; // [RULE3]
					st_next.mode_a = st_reg.ma_f; // [RULE3]
				end else begin
					st_next.settle = st_reg.settle + 3'h1;
				end
			end

			// watchdog counter and service sequence
			if (e_tick) begin
				st_next.wd_cnt = (st_reg.wd_cnt == wd_limit(st_reg.opt[1:0])) ?
					'0 : st_reg.wd_cnt + 21'h000001; // [RULE7]
			end
			if (svc_wr && wdata_i == wdog_pkg::SERVICE_ARM) begin
				st_next.armed = 1'b1; // [RULE9] [RULE11]
			end else if (svc_wr && wdata_i == wdog_pkg::SERVICE_FIRE &&
				st_reg.armed) begin
				st_next.armed = 1'b0;
				st_next.wd_cnt = '0; // [RULE10] [RULE24]
			end

			// clock monitor: system clocks since last rising e edge
			if (e_tick || !st_reg.opt[wdog_pkg::OPT_MON_BIT]) begin
				st_next.cm_cnt = '0;
			end else if (st_reg.cm_cnt != 16'hFFFF) begin
				st_next.cm_cnt = st_reg.cm_cnt + 16'h0001;
			end

			// option lock window
			if (!st_reg.locked && e_tick) begin
				st_next.lock_cnt = st_reg.lock_cnt + 7'h01;
				if (st_reg.lock_cnt == wdog_pkg::LOCK_TICKS - 7'h01) begin
					st_next.locked = 1'b1; // [RULE18]
				end
			end

			// register writes
			if (opt_wr) begin
				st_next.opt = (st_reg.opt & ~wdog_pkg::OPT_FREE_MASK) |
					(wdata_i & wdog_pkg::OPT_FREE_MASK); // [RULE17]
				if (!st_reg.locked || st_reg.spec) begin
					st_next.opt = (wdata_i & (wdog_pkg::OPT_FREE_MASK |
						wdog_pkg::OPT_ONCE_MASK)); // [RULE17] [RULE19] [RULE23]
					st_next.locked = ~st_reg.spec;
				end
			end
			if (wr_i && addr_i == wdog_pkg::ADDR_PRIORITY) begin
				st_next.psel = wdata_i[3:0];
			end
			if (wr_i && addr_i == wdog_pkg::ADDR_TEST && st_reg.spec) begin
				st_next.wd_block = wdata_i[0]; // [RULE6]
			end

			// edge-mode irq latch, a new edge beats the ack
			if (irq_ack_i) begin
				st_next.irq_pend = 1'b0;
			end
			if (st_reg.opt[wdog_pkg::OPT_EDGE_BIT] && st_reg.irq_f &&
				!st_next.irq_f) begin
				st_next.irq_pend = 1'b1; // [RULE20]
			end

			// stop exit delay
			if (wake_i && st_reg.opt[wdog_pkg::OPT_WAIT_BIT]) begin
				st_next.stop_wait = 1'b1; // [RULE21]
				st_next.stop_cnt = '0;
			end else if (st_reg.stop_wait && e_tick) begin
				st_next.stop_cnt = st_reg.stop_cnt + 12'h001;
				if (st_reg.stop_cnt == wdog_pkg::STOP_DELAY_TICKS - 12'h001) begin
					st_next.stop_wait = 1'b0; // [RULE21]
				end
			end
		end

		// reset pin sequencer
		unique case (st_reg.phase)
			wdog_pkg::RS_IDLE: begin
				st_next.ph_cnt = '0;
				if (!st_reg.pin_f) begin
					st_next.cause = wdog_pkg::CAUSE_EXT;
				end else if (cm_fail) begin
					st_next.phase = wdog_pkg::RS_DRIVE; // [RULE15]
					st_next.cause = wdog_pkg::CAUSE_CMON; // [RULE15]
				end else if (wd_fire) begin
					st_next.phase = wdog_pkg::RS_DRIVE; // [RULE6]
					st_next.cause = wdog_pkg::CAUSE_WDOG; // [RULE13]
				end
			end
			wdog_pkg::RS_DRIVE: begin
				if (e_tick) begin
					st_next.ph_cnt = st_reg.ph_cnt + 3'h1;
					if (st_reg.ph_cnt == wdog_pkg::DRIVE_TICKS - 3'h1) begin
						st_next.phase = wdog_pkg::RS_SAMPLE;
						st_next.ph_cnt = '0;
					end
				end
			end
			wdog_pkg::RS_SAMPLE: begin
				if (e_tick) begin
					st_next.ph_cnt = st_reg.ph_cnt + 3'h1;
					if (st_reg.ph_cnt == wdog_pkg::SAMPLE_TICKS - 3'h1) begin
						st_next.phase = wdog_pkg::RS_IDLE;
						if (!st_reg.pin_f) begin
							st_next.cause = wdog_pkg::CAUSE_EXT;
						end
					end
				end
			end
			default: begin
				st_next.phase = wdog_pkg::RS_IDLE;
			end
		endcase

		// read data, one cycle after the strobe
		st_next.rdata = wdog_pkg::READ_JUNK;
		if (rd_i) begin
			unique case (addr_i)
				wdog_pkg::ADDR_OPTIONS: st_next.rdata = st_reg.opt & 8'hFB; // [RULE23]
				wdog_pkg::ADDR_SERVICE: st_next.rdata = wdog_pkg::READ_JUNK; // [RULE12]
				wdog_pkg::ADDR_PRIORITY: st_next.rdata = {st_reg.boot,
					st_reg.spec, st_reg.mode_a, 1'b0, st_reg.psel};
				wdog_pkg::ADDR_TEST: st_next.rdata = {7'h00, st_reg.wd_block};
				default: st_next.rdata = wdog_pkg::READ_JUNK;
			endcase
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			st_reg <= ST_INIT;
		end else begin
			st_reg <= st_next;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign rdata_o = st_reg.rdata;
	assign reset_pin_o = 1'b0;
	assign reset_pin_oe_n_o = (st_reg.phase != wdog_pkg::RS_DRIVE); // [RULE15]
	assign sys_reset_o = (st_reg.phase != wdog_pkg::RS_IDLE) | ~st_reg.pin_f;
	assign reset_cause_o = st_reg.cause; // [RULE13]
	assign irq_request_o = st_reg.opt[wdog_pkg::OPT_EDGE_BIT] ?
		st_reg.irq_pend : ~st_reg.irq_f; // [RULE20]
	assign priority_select_o = st_reg.psel;
	assign boot_rom_enable_o = st_reg.boot;
	assign special_mode_flag_o = st_reg.spec;
	assign mode_a_flag_o = st_reg.mode_a;
	assign run_enable_o = ~st_reg.stop_wait;
	assign converter_power_up_o = st_reg.opt[wdog_pkg::OPT_PWR_BIT];
	assign rc_osc_enable_o = st_reg.opt[wdog_pkg::OPT_PUMP_BIT]; // [RULE22]
	assign converter_e_clk_o = ~st_reg.opt[wdog_pkg::OPT_PUMP_BIT]; // [RULE22]

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	sequence s_drive_done;
		st_reg.phase == wdog_pkg::RS_DRIVE && e_tick &&
			st_reg.ph_cnt == wdog_pkg::DRIVE_TICKS - 3'h1;
	endsequence

	sequence s_enter_sample;
		st_reg.phase == wdog_pkg::RS_SAMPLE && reset_pin_oe_n_o;
	endsequence

	bit2_reads_zero_a: assert property (rd_i && addr_i ==
		wdog_pkg::ADDR_OPTIONS |=> !rdata_o[2]) // [RULE23]
		else $error("option bit 2 read as one");
	service_read_inert_a: assert property (rd_i && !wr_i && !e_tick &&
		!sys_rst && addr_i == wdog_pkg::ADDR_SERVICE
		|=> st_reg.wd_cnt == $past(st_reg.wd_cnt)) // [RULE12]
		else $error("service read disturbed the watchdog");
	service_restart_a: assert property (!sys_rst && svc_wr &&
		st_reg.armed && wdata_i == wdog_pkg::SERVICE_FIRE
		|=> st_reg.wd_cnt == '0 && !st_reg.armed) // [RULE24]
		else $error("armed service did not restart watchdog");
	locked_bits_hold_a: assert property (!sys_rst && opt_wr &&
		st_reg.locked && !st_reg.spec
		|=> (st_reg.opt & wdog_pkg::OPT_ONCE_MASK) ==
		($past(st_reg.opt) & wdog_pkg::OPT_ONCE_MASK)) // [RULE18]
		else $error("locked option bits changed");
	monitor_fires_a: assert property (!sys_rst &&
		st_reg.phase == wdog_pkg::RS_IDLE &&
		st_reg.opt[wdog_pkg::OPT_MON_BIT] &&
		st_reg.cm_cnt >= CM_TIMEOUT - 16'h0001
		|=> !reset_pin_oe_n_o && reset_cause_o == wdog_pkg::CAUSE_CMON) // [RULE14]
		else $error("clock monitor timeout missed");
	stop_monitor_a: assert property (!sys_rst &&
		st_reg.phase == wdog_pkg::RS_IDLE && stop_i &&
		st_reg.opt[wdog_pkg::OPT_MON_BIT]
		|=> st_reg.phase == wdog_pkg::RS_DRIVE) // [RULE16]
		else $error("stop with monitor did not reset");
	drive_release_a: assert property (s_drive_done
		|=> s_enter_sample) // [RULE15]
		else $error("reset pin drive did not end after four e clocks");
	wdog_disabled_a: assert property (st_reg.phase == wdog_pkg::RS_IDLE &&
		watchdog_disable_i && st_reg.pin_f && !cm_fail
		|=> st_reg.phase == wdog_pkg::RS_IDLE) // [RULE6]
		else $error("disabled watchdog caused a reset");
	irq_level_a: assert property (!st_reg.opt[wdog_pkg::OPT_EDGE_BIT] &&
		!st_reg.irq_f
		|-> irq_request_o) // [RULE20]
		else $error("low irq level not requested");
	stop_delay_a: assert property (!sys_rst && wake_i &&
		st_reg.opt[wdog_pkg::OPT_WAIT_BIT]
		|=> !run_enable_o [*2]) // [RULE21]
		else $error("stop exit delay not applied");

endmodule : cop_watchdog_clock_monitor

// ==== dv/wdog_board_model.sv ====
/*
 * board side of the watchdog block: e clock source and reset pin wire.
 * assumes the device only pulls the reset pin low; a pull-up does the rest.
 */
`timescale 1ns/1ps

module wdog_board_model (
	// bench control
	input wire logic e_run_i,
	// reset pin from the device
	input wire logic pin_drive_i,
	input wire logic pin_oe_n_i,
	// to the device
	output logic e_clk_o,
	output logic pin_level_o
);
	logic e_q = 1'b0;

	// e clock stands still while e_run_i is low
	always begin
		#12;
		if (e_run_i) begin
			e_q = ~e_q;
		end
	end

	assign e_clk_o = e_q;
	// pull-up lifts the pin at once when released
	assign pin_level_o = pin_oe_n_i ? 1'b1 : pin_drive_i;
endmodule : wdog_board_model

// ==== dv/tb_cop_watchdog_clock_monitor.sv ====
/*
 * self-checking bench of the watchdog, clock monitor and option logic.
 * assumes the board model makes the e clock and the reset pin level.
 */
`timescale 1ns/1ps

module tb_cop_watchdog_clock_monitor;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [15:0] addr_i = 16'h0000;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic irq_n = 1'b1;
	logic mode_a = 1'b0;
	logic mode_b = 1'b1;
	logic wd_dis = 1'b1;
	logic stop = 1'b0;
	logic e_run = 1'b1;
	logic wake = 1'b0;
	logic irq_ack = 1'b0;
	logic e_clk, pin_lvl, pin_o, oe_n, sys_rst, irq_req, run_en;
	logic [1:0] cause;
	logic [3:0] psel;
	logic [7:0] rdata_o;
	logic boot, spec, ma_flag, pwr_up, rc_osc, conv_e;
	int error_cnt = 0;
	int num_checks = 0;

	always #2 mclk_i = ~mclk_i;

	wdog_board_model board_u (
		.e_run_i(e_run), .pin_drive_i(pin_o), .pin_oe_n_i(oe_n),
		.e_clk_o(e_clk), .pin_level_o(pin_lvl)
	);

	cop_watchdog_clock_monitor #(.CM_TIMEOUT(16'h0028), .WD_SHIFT(4)) dut_u (
		.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .e_clk_i(e_clk),
		.reset_pin_i(pin_lvl), .reset_pin_o(pin_o), .reset_pin_oe_n_o(oe_n),
		.irq_pin_n_i(irq_n), .mode_select_a_input_i(mode_a),
		.mode_select_b_input_i(mode_b), .watchdog_disable_i(wd_dis),
		.stop_i(stop), .wake_i(wake), .run_enable_o(run_en),
		.sys_reset_o(sys_rst), .reset_cause_o(cause),
		.irq_request_o(irq_req), .irq_ack_i(irq_ack),
		.priority_select_o(psel), .boot_rom_enable_o(boot),
		.special_mode_flag_o(spec), .mode_a_flag_o(ma_flag),
		.converter_power_up_o(pwr_up), .rc_osc_enable_o(rc_osc),
		.converter_e_clk_o(conv_e)
	);

	// ****************************************************************
	// helpers
	// ****************************************************************
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask : rd

	// system reset must stay low for n cycles
	task automatic quiet(input int n);
		logic bad;
		bad = 1'b0;
		repeat (n) begin
			@(posedge mclk_i);
			#1;
			if (sys_rst !== 1'b0) begin
				bad = 1'b1;
			end
		end
		chk({7'h00, bad}, 8'h00);
	endtask : quiet

	task automatic wait_rst(input logic v, input int lim);
		int n;
		n = 0;
		while (sys_rst !== v && n < lim) begin
			@(posedge mclk_i);
			#1;
			n++;
		end
		chk({7'h00, sys_rst}, {7'h00, v});
	endtask : wait_rst

	// option value after a write, normal mode
	function automatic logic [7:0] opt_exp(input logic [7:0] old,
		input logic [7:0] nv, input logic first);
		if (first) begin
			return nv & 8'hFB;
		end
		return (nv & 8'hC8) | (old & 8'h33);
	endfunction : opt_exp

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		#200000;
		error_cnt++;
		wrap_up();
	end

	initial begin
		logic [7:0] v1, v2, e1, d;
		int n;
		void'($urandom(95869));
		mode_a = 1'($urandom);
		repeat (5) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (12) @(posedge mclk_i);
		rd(wdog_pkg::ADDR_OPTIONS, d);
		chk(d, 8'h10);
		rd(wdog_pkg::ADDR_PRIORITY, d);
		chk(d, {2'b00, mode_a, 1'b0, 4'h5});
		chk({4'h0, psel}, 8'h05);
		@(posedge mclk_i);
		irq_n <= 1'b0;
		repeat (8) @(posedge mclk_i);
		chk({7'h00, irq_req}, 8'h01);
		irq_n <= 1'b1;
		repeat (8) @(posedge mclk_i);
		chk({7'h00, irq_req}, 8'h00);
		// first write: rate 01, bit 2 set, monitor off
		v1 = (8'($urandom) & 8'hF4) | 8'h05;
		wr(wdog_pkg::ADDR_OPTIONS, v1);
		e1 = opt_exp(8'h10, v1, 1'b1);
		rd(wdog_pkg::ADDR_OPTIONS, d);
		chk(d, e1);
		chk({6'h00, pwr_up, rc_osc}, {6'h00, v1[7:6]});
		chk({7'h00, conv_e}, {7'h00, ~v1[6]});
		v2 = 8'($urandom) & 8'hF7;
		wr(wdog_pkg::ADDR_OPTIONS, v2);
		rd(wdog_pkg::ADDR_OPTIONS, d);
		chk(d, opt_exp(e1, v2, 1'b0));
		wr(wdog_pkg::ADDR_SERVICE, 8'h55);
		wr(wdog_pkg::ADDR_SERVICE, 8'hAA);
		quiet(500);
		wr(wdog_pkg::ADDR_SERVICE, 8'h55);
		wr(wdog_pkg::ADDR_SERVICE, 8'hAA);
		@(posedge mclk_i);
		wd_dis <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			wr(wdog_pkg::ADDR_SERVICE, 8'h55);
			rd(wdog_pkg::ADDR_SERVICE, d);
			chk(d, 8'h00);
			rd(16'h1000, d);
			chk(d, 8'h00);
			wr(wdog_pkg::ADDR_PRIORITY, 8'h05);
			quiet(100);
			wr(wdog_pkg::ADDR_SERVICE, 8'hAA);
			quiet(150);
		end
		quiet(50);
		wr(wdog_pkg::ADDR_SERVICE, 8'hAA);
		wait_rst(1'b1, 260);
		wd_dis <= 1'b1;
		chk({6'h00, cause}, 8'h01);
		chk({7'h00, oe_n}, 8'h00);
		wait_rst(1'b0, 300);
		rd(wdog_pkg::ADDR_OPTIONS, d);
		chk(d, 8'h10);
		// no write inside the window: once-bits lock
		quiet(450);
		wr(wdog_pkg::ADDR_OPTIONS, 8'h3B);
		rd(wdog_pkg::ADDR_OPTIONS, d);
		chk(d, 8'h18);
		@(posedge mclk_i);
		e_run <= 1'b0;
		wait_rst(1'b1, 60);
		chk({6'h00, cause}, 8'h02);
		chk({6'h00, oe_n, pin_o}, 8'h00);
		e_run <= 1'b1;
		wait_rst(1'b0, 300);
		wr(wdog_pkg::ADDR_OPTIONS, 8'h08);
		@(posedge mclk_i);
		stop <= 1'b1;
		wait_rst(1'b1, 20);
		chk({6'h00, cause}, 8'h02);
		stop <= 1'b0;
		wait_rst(1'b0, 300);
		// special mode: every option bit stays writable
		@(posedge mclk_i);
		rst_i <= 1'b1;
		mode_b <= 1'b0;
		repeat (10) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (12) @(posedge mclk_i);
		chk({6'h00, spec, boot}, {6'h00, 1'b1, ~mode_a});
		chk({7'h00, ma_flag}, {7'h00, mode_a});
		wr(wdog_pkg::ADDR_OPTIONS, 8'h01);
		wr(wdog_pkg::ADDR_OPTIONS, 8'h02);
		rd(wdog_pkg::ADDR_OPTIONS, d);
		chk(d, 8'h02);
		// delay bit clear: wake-up resumes at once
		@(posedge mclk_i);
		wake <= 1'b1;
		@(posedge mclk_i);
		wake <= 1'b0;
		repeat (4) @(posedge mclk_i);
		chk({7'h00, run_en}, 8'h01);
		// edge mode: a falling edge stays latched until acknowledged
		wr(wdog_pkg::ADDR_OPTIONS, 8'h30);
		@(posedge mclk_i);
		irq_n <= 1'b0;
		repeat (8) @(posedge mclk_i);
		irq_n <= 1'b1;
		repeat (8) @(posedge mclk_i);
		chk({7'h00, irq_req}, 8'h01);
		irq_ack <= 1'b1;
		@(posedge mclk_i);
		irq_ack <= 1'b0;
		repeat (3) @(posedge mclk_i);
		chk({7'h00, irq_req}, 8'h00);
		// delay bit set: 4064 e clocks of 6 system clocks each
		wake <= 1'b1;
		@(posedge mclk_i);
		wake <= 1'b0;
		#1;
		n = 0;
		while (run_en !== 1'b1 && n < 30000) begin
			@(posedge mclk_i);
			#1;
			n++;
		end
		n = n - 4064 * 6;
		chk({7'h00, n > -16 && n < 16}, 8'h01);
		wrap_up();
	end
endmodule : tb_cop_watchdog_clock_monitor
